// *** hdl/tfm_map.vh ***
// Purpose: Constants for the fine-mode measure control block
// Assumes: 20 MHz system clock, 4-bit register address
// Notes: Register indices equal bus addresses
`ifndef TFM_MAP_VH
`define TFM_MAP_VH
`define TFM_REG_EDGE 4'h0
`define TFM_REG_MASK 4'h2
`define TFM_REG_TEST 4'h3
`define TFM_REG_CTRL 4'h4
`define TFM_REG_OPT 4'h5
`define TFM_REG_FILL 4'h6
`define TFM_REG_TIMER 4'h7
`define TFM_REG_FIFO1 4'h8
`define TFM_REG_FIFO2 4'h9
`define TFM_REG_STAT 4'hA
`define TFM_REG_ERRM 4'hB
`define TFM_REG_IRQM 4'hC
`define TFM_REG_BUS 4'hE
`define TFM_BUS16_VAL 28'h0000010
`define TFM_FINE_DIV 5'h1F
// Idle level of every synchronised pin, so no false edge follows reset
`define TFM_PIN_IDLE 18'h3C006
// Register 0: rising select bits 0..2, falling select bits 3..5 (start, stop1, stop2)
`define TFM_RISE_LSB 0
`define TFM_FALL_LSB 3
// Register 2: mask bits 3..8, stop1 uses 3..5, stop2 uses 6..8
`define TFM_MASK1_LSB 3
`define TFM_MASK2_LSB 6
// Register 3
`define TFM_DIV_LSB 0
`define TFM_TEST_BIT 27
// Register 4
`define TFM_MRST_BIT 22
`define TFM_PRST_BIT 23
`define TFM_TRIG_BIT 24
`define TFM_QUIET_BIT 13
`define TFM_FINE_BIT 9
`define TFM_TSTART_BIT 8
`define TFM_TSTOP_BIT 10
// Register 5
`define TFM_OFF_LSB 0
`define TFM_STOPHOLD_BIT 21
`define TFM_STARTLOCK_BIT 22
`define TFM_MTRIG_BIT 23
`define TFM_MOE_BIT 24
`define TFM_PTRIG_BIT 25
`define TFM_POE_BIT 26
// Register 6
`define TFM_FILL_LSB 0
`define TFM_DIFFPWR_BIT 27
// Register 11 and 12 event bit positions
`define TFM_ERR_HIT_BIT 16
`define TFM_ERR_IF1_BIT 24
`define TFM_ERR_IF2_BIT 25
`define TFM_ERR_PLL_BIT 26
`define TFM_IRQ_HIT_BIT 13
`define TFM_IRQ_IF1_BIT 21
`define TFM_IRQ_IF2_BIT 22
`define TFM_IRQ_PLL_BIT 23
`define TFM_IRQ_EMPTY_BIT 24
`define TFM_IRQ_TIMER_BIT 25
// Timing
`define TFM_CLK_NS 50
`define TFM_HOLD_NS 7
`define TFM_RST_NS 40
`define TFM_PRST_NS 75
`define TFM_PROC_NS 900
`endif

// *** hdl/tfm_fifo.v ***
// Purpose: Interface FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high clear
// Notes: Storage in flip-flops
`timescale 1ns/100ps
`default_nettype none
module tfm_fifo #(
  parameter WIDTH = 28,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk_in,
  input wire clr_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire wr_valid_in,
  output wire wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire rd_valid_out,
  input wire rd_ready_in,
  output wire [AW:0] level_out
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire do_wr;
  wire do_rd;
  // Handshakes
  assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
  assign rd_valid_out = (cnt_q != {(AW+1){1'b0}});
  assign do_wr = wr_valid_in & wr_ready_out;
  assign do_rd = rd_ready_in & rd_valid_out;
  assign rd_data_out = mem_q[rp_q];
  assign level_out = cnt_q;
  // Pointers and count
  always @(posedge sys_clk_in)
  begin
    if (clr_in)
    begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        mem_q[wp_q] <= wr_data_in;
        wp_q <= wp_q + 1'b1;
      end
      if (do_rd)
        rp_q <= rp_q + 1'b1;
      if (do_wr & ~do_rd)
        cnt_q <= cnt_q + 1'b1;
      else if (do_rd & ~do_wr)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** hdl/tfm_ctrl.v ***
// Purpose: Fine-mode measure control and readout of a time-to-digital converter
// Assumes: Host bus and pins are synchronised to sys_clk_in; time base is the system clock
// Notes: Results are coarse counts scaled by the fine divider plus one; analog loop not modelled
// How it works
// - Each channel reacts to rising, falling, or both edges; none disables.
// - Stops are blocked by per-edge pins and by triples of software mask bits.
// - Inputs open after reset; optional stop hold until start plus 7 ns.
// - Only first start used; optional lock closes start channel after it.
// - An 18-bit start offset is added to each scaled stop result.
// - Stop events buffered, start subtracted, results moved to channel FIFOs.
// - Bus is 28 bits; writing 0x10 to address 14 selects 16-bit mode.
// - Each channel FIFO shows active-high empty and level flags.
// - One fill threshold for both FIFOs raises level flag when reached.
// - Quiet mode: processing starts on trigger edge or software bit, 900 ns.
// - Result in low bits, upper unused; channel 1 at 8, channel 2 at 9.
// - Power-up reset pin low resets whole chip except bus_data_out, including configuration.
// - Master reset clears all but configuration and bus_data_out, from register 4 or pins.
// - Partial reset also keeps FIFOs, from register 4 or enabled pins.
// - Inputs ignore data 40 ns after master reset, 75 ns after partial.
// - Interval timer from register 7 starts on start or stop, flags on expiry.
// - Interrupt flag ORs unmasked events of register 12 bits 21 to 25.
// - Error flag ORs unmasked events of register 11 bits 24 to 26.
// - Test select routes three test inputs instead of measurement inputs.
// - Fine mode active when divider is 31 and fine enable bit set.
// - In fine mode one stop hit per channel per start.
`timescale 1ns/100ps
`default_nettype none
`include "tfm_map.vh"
module tfm_ctrl #(
  parameter DW = 28,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk_in,
  input wire srst_in,
  input wire power_up_reset_n_in,
  input wire bus_cs_n_in,
  input wire bus_rd_n_in,
  input wire bus_wr_n_in,
  input wire [3:0] bus_addr_in,
  input wire [DW-1:0] bus_data_in,
  output reg [DW-1:0] bus_data_out,
  output wire bus_data_oe_n_out,
  input wire start_in,
  input wire stop1_in,
  input wire stop2_in,
  input wire test_start_in,
  input wire test_stop1_in,
  input wire test_stop2_in,
  input wire [3:0] stop_input_block_pin_in,
  input wire post_process_trigger_pin_in,
  input wire output_drive_pin_n_in,
  input wire pll_locked_in,
  output wire fifo_empty_flag1_out,
  output wire fifo_empty_flag2_out,
  output wire fifo_level_flag1_out,
  output wire fifo_level_flag2_out,
  output wire irq_flag_out,
  output wire err_flag_out,
  output wire diff_input_power_on_out,
  output wire bus16_mode_out
);
  localparam HOLD_CYC = (`TFM_HOLD_NS + `TFM_CLK_NS - 1) / `TFM_CLK_NS;
  localparam RST_CYC = (`TFM_RST_NS + `TFM_CLK_NS - 1) / `TFM_CLK_NS;
  localparam PRST_CYC = (`TFM_PRST_NS + `TFM_CLK_NS - 1) / `TFM_CLK_NS;
  localparam PROC_CYC = `TFM_PROC_NS / `TFM_CLK_NS;
  localparam S_IDLE = 2'h0;
  localparam S_CALC = 2'h1;
  localparam S_PUSH = 2'h2;
  // *****************************************
  // Input synchronisers
  // *****************************************
  localparam NS = 18;
  wire [NS-1:0] raw_w;
  reg [NS-1:0] s1_q;
  reg [NS-1:0] s2_q;
  reg [NS-1:0] s3_q;
  assign raw_w = {power_up_reset_n_in, bus_cs_n_in, bus_rd_n_in, bus_wr_n_in, start_in, stop1_in, stop2_in,
    test_start_in, test_stop1_in, test_stop2_in, stop_input_block_pin_in, post_process_trigger_pin_in,
    output_drive_pin_n_in, pll_locked_in, 1'b0};
  // Two stages then a history stage for edges
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      s1_q <= `TFM_PIN_IDLE;
      s2_q <= `TFM_PIN_IDLE;
      s3_q <= `TFM_PIN_IDLE;
    end
    else
    begin
      s1_q <= raw_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  wire pur_n = s2_q[17];
  wire wr_fall = ~s2_q[16] & ~s2_q[14] & s3_q[14];
  wire rd_fall = ~s2_q[16] & ~s2_q[15] & s3_q[15];
  wire rd_act = ~s2_q[16] & ~s2_q[15];
  wire [3:0] blk_pin = s2_q[7:4];
  wire trig_rise = s2_q[3] & ~s3_q[3];
  wire oe_low = ~s2_q[2];
  wire pll_ok = s2_q[1];
  // *****************************************
  // Configuration registers
  // *****************************************
  reg [DW-1:0] r0_q, r2_q, r3_q, r4_q, r5_q, r6_q, r7_q, r11_q, r12_q;
  reg bus16_q;
  reg half_q;
  reg [15:0] lo_q;
  wire cfg_rst = srst_in | ~pur_n;
  // 16-bit mode collects low word then high word before a write takes effect
  wire wr_full = wr_fall & (~bus16_q | half_q);
  wire [DW-1:0] wdat = bus16_q ? {bus_data_in[11:0], lo_q} : bus_data_in;
  always @(posedge sys_clk_in)
  begin
    if (cfg_rst)
    begin
      r0_q <= 28'h0000000;
      r2_q <= 28'h0000000;
      r3_q <= 28'h0000000;
      r4_q <= 28'h0000000;
      r5_q <= 28'h0000000;
      r6_q <= 28'h0000000;
      r7_q <= 28'h0000000;
      r11_q <= 28'h0000000;
      r12_q <= 28'h0000000;
      bus16_q <= 1'b0;
      half_q <= 1'b0;
      lo_q <= 16'h0000;
    end
    else
    begin
      if (bus16_q & (wr_fall | rd_fall))
        half_q <= ~half_q;
      if (bus16_q & wr_fall & ~half_q)
        lo_q <= bus_data_in[15:0];
      if (wr_full)
      begin
        case (bus_addr_in)
          `TFM_REG_EDGE: r0_q <= wdat;
          `TFM_REG_MASK: r2_q <= wdat;
          `TFM_REG_TEST: r3_q <= wdat;
          `TFM_REG_CTRL: r4_q <= wdat & ~(28'h1 << `TFM_TRIG_BIT); // Trigger bit self-clears
          `TFM_REG_OPT: r5_q <= wdat;
          `TFM_REG_FILL: r6_q <= wdat;
          `TFM_REG_TIMER: r7_q <= wdat;
          `TFM_REG_ERRM: r11_q <= wdat;
          `TFM_REG_IRQM: r12_q <= wdat;
          `TFM_REG_BUS:
          begin
            bus16_q <= (wdat == `TFM_BUS16_VAL);
            half_q <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end
  assign bus16_mode_out = bus16_q;
  assign diff_input_power_on_out = r6_q[`TFM_DIFFPWR_BIT];
  wire ctrl_wr = wr_full & (bus_addr_in == `TFM_REG_CTRL);
  wire quiet = r4_q[`TFM_QUIET_BIT];
  wire fine_on = r4_q[`TFM_FINE_BIT] & (r3_q[`TFM_DIV_LSB +: 5] == `TFM_FINE_DIV);
  // *****************************************
  // Resets and input recovery
  // *****************************************
  wire mrst = cfg_rst | (ctrl_wr & wdat[`TFM_MRST_BIT])
    | (quiet & r5_q[`TFM_MOE_BIT] & oe_low)
    | (~quiet & r5_q[`TFM_MTRIG_BIT] & s2_q[3]);
  wire prst = (ctrl_wr & wdat[`TFM_PRST_BIT])
    | (quiet & r5_q[`TFM_POE_BIT] & oe_low)
    | (~quiet & r5_q[`TFM_PTRIG_BIT] & s2_q[3]);
  wire anyrst = mrst | prst;
  reg [3:0] rec_q;
  // Recovery counter keeps inputs closed after a reset
  always @(posedge sys_clk_in)
  begin
    if (mrst)
      rec_q <= RST_CYC[3:0];
    else if (prst)
      rec_q <= PRST_CYC[3:0];
    else if (rec_q != 4'h0)
      rec_q <= rec_q - 4'h1;
  end
  wire inputs_open = (rec_q == 4'h0) & ~anyrst;
  // *****************************************
  // Edge detection and channel gating
  // *****************************************
  wire tsel = r3_q[`TFM_TEST_BIT];
  wire [2:0] lvl_now = tsel ? s2_q[10:8] : s2_q[13:11];
  wire [2:0] lvl_old = tsel ? s3_q[10:8] : s3_q[13:11];
  wire [2:0] ev;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_edge
      // Index 2 is start, 1 is stop1, 0 is stop2
      assign ev[gi] = (r0_q[`TFM_RISE_LSB + 2 - gi] & lvl_now[gi] & ~lvl_old[gi])
        | (r0_q[`TFM_FALL_LSB + 2 - gi] & ~lvl_now[gi] & lvl_old[gi]);
    end
  endgenerate
  // Per-edge pin blocks and triple mask bits for each stop
  wire rise1 = lvl_now[1] & ~lvl_old[1];
  wire rise2 = lvl_now[0] & ~lvl_old[0];
  wire blk1 = (rise1 ? blk_pin[0] : blk_pin[1]) | (&r2_q[`TFM_MASK1_LSB +: 3]);
  wire blk2 = (rise2 ? blk_pin[2] : blk_pin[3]) | (&r2_q[`TFM_MASK2_LSB +: 3]);
  reg started_q;
  reg [1:0] hold_q;
  reg [1:0] got_q;
  reg [13:0] tcnt_q;
  reg [12:0] tmr_q;
  reg tmr_end_q;
  wire start_ok = ev[2] & inputs_open & ~(started_q & r5_q[`TFM_STARTLOCK_BIT]);
  wire stop_gate = inputs_open & (~r5_q[`TFM_STOPHOLD_BIT] | (started_q & hold_q == 2'h0));
  wire hit1 = ev[1] & ~blk1 & stop_gate & ~(fine_on & got_q[1]);
  wire hit2 = ev[0] & ~blk2 & stop_gate & ~(fine_on & got_q[0]);
  reg [22:0] t1_q, t2_q, ts_q;
  // Measurement state: start stamp, stop stamps, time base
  always @(posedge sys_clk_in)
  begin
    if (anyrst)
    begin
      started_q <= 1'b0;
      hold_q <= 2'h0;
      got_q <= 2'h0;
      tcnt_q <= 14'h0000;
      ts_q <= 23'h000000;
      t1_q <= 23'h000000;
      t2_q <= 23'h000000;
    end
    else
    begin
      tcnt_q <= tcnt_q + 14'h0001;
      if (hold_q != 2'h0)
        hold_q <= hold_q - 2'h1;
      if (start_ok & ~started_q)
      begin
        started_q <= 1'b1;
        ts_q <= {9'h000, tcnt_q};
        hold_q <= HOLD_CYC[1:0];
        got_q <= 2'h0;
      end
      if (hit1)
      begin
        got_q[1] <= 1'b1;
        t1_q <= {9'h000, tcnt_q};
      end
      if (hit2)
      begin
        got_q[0] <= 1'b1;
        t2_q <= {9'h000, tcnt_q};
      end
    end
  end
  // *****************************************
  // Post-processing
  // *****************************************
  reg [1:0] st_q;
  reg [5:0] pc_q;
  reg [DW-1:0] res1_q, res2_q;
  reg [1:0] pend_q;
  wire w1_rdy, w2_rdy;
  wire sw_trig = ctrl_wr & wdat[`TFM_TRIG_BIT];
  wire go = quiet & (trig_rise | sw_trig);
  // Result = (stop - start) times (divider + 1), plus offset, in fine bins
  function [DW-1:0] calc;
    input [22:0] stp;
    input [22:0] sta;
    input [4:0] dv;
    input [17:0] off;
    reg [27:0] d;
    begin
      d = {5'h00, stp - sta} * ({23'h000000, dv} + 28'h0000001);
      calc = {5'h00, d[22:0] + {5'h00, off}};
    end
  endfunction
  // Trigger waits out the processing latency, then pushes into FIFOs
  always @(posedge sys_clk_in)
  begin
    if (anyrst)
    begin
      st_q <= S_IDLE;
      pc_q <= 6'h00;
      pend_q <= 2'h0;
      res1_q <= 28'h0000000;
      res2_q <= 28'h0000000;
    end
    else
    begin
      case (st_q)
        S_IDLE:
          if (go)
          begin
            st_q <= S_CALC;
            pc_q <= PROC_CYC[5:0];
            res1_q <= calc(t1_q, ts_q, r3_q[`TFM_DIV_LSB +: 5], r5_q[`TFM_OFF_LSB +: 18]);
            res2_q <= calc(t2_q, ts_q, r3_q[`TFM_DIV_LSB +: 5], r5_q[`TFM_OFF_LSB +: 18]);
            pend_q <= got_q;
          end
        S_CALC:
          if (pc_q <= 6'h2)
            st_q <= S_PUSH;
          else
            pc_q <= pc_q - 6'h01;
        S_PUSH:
        begin
          if (w1_rdy)
            pend_q[1] <= 1'b0;
          if (w2_rdy)
            pend_q[0] <= 1'b0;
          if ((~pend_q[1] | w1_rdy) & (~pend_q[0] | w2_rdy))
            st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // *****************************************
  // Interface FIFOs and readout
  // *****************************************
  wire [DW-1:0] f1_d, f2_d;
  wire f1_v, f2_v;
  wire [AW:0] lv1, lv2;
  wire fclr = mrst;
  wire rd_fire = rd_fall & (~bus16_q | half_q);
  wire rd1 = rd_fire & (bus_addr_in == `TFM_REG_FIFO1);
  wire rd2 = rd_fire & (bus_addr_in == `TFM_REG_FIFO2);
  tfm_fifo #(.WIDTH(DW), .DEPTH(DEPTH), .AW(AW)) u_fifo1 (
    .sys_clk_in(sys_clk_in),
    .clr_in(fclr),
    .wr_data_in(res1_q),
    .wr_valid_in((st_q == S_PUSH) & pend_q[1]),
    .wr_ready_out(w1_rdy),
    .rd_data_out(f1_d),
    .rd_valid_out(f1_v),
    .rd_ready_in(rd1),
    .level_out(lv1)
  );
  tfm_fifo #(.WIDTH(DW), .DEPTH(DEPTH), .AW(AW)) u_fifo2 (
    .sys_clk_in(sys_clk_in),
    .clr_in(fclr),
    .wr_data_in(res2_q),
    .wr_valid_in((st_q == S_PUSH) & pend_q[0]),
    .wr_ready_out(w2_rdy),
    .rd_data_out(f2_d),
    .rd_valid_out(f2_v),
    .rd_ready_in(rd2),
    .level_out(lv2)
  );
  wire [7:0] fill = r6_q[`TFM_FILL_LSB +: 8];
  assign fifo_empty_flag1_out = ~f1_v;
  assign fifo_empty_flag2_out = ~f2_v;
  assign fifo_level_flag1_out = (fill != 8'h00) & ({{(7-AW){1'b0}}, lv1} >= fill);
  assign fifo_level_flag2_out = (fill != 8'h00) & ({{(7-AW){1'b0}}, lv2} >= fill);
  // *****************************************
  // Interval timer and flags
  // *****************************************
  wire tmr_go = (r4_q[`TFM_TSTART_BIT] & start_ok) | (r4_q[`TFM_TSTOP_BIT] & (hit1 | hit2));
  always @(posedge sys_clk_in)
  begin
    if (anyrst)
    begin
      tmr_q <= 13'h0000;
      tmr_end_q <= 1'b0;
    end
    else if (tmr_go & (tmr_q == 13'h0000))
    begin
      tmr_q <= r7_q[12:0];
      tmr_end_q <= 1'b0;
    end
    else if (tmr_q != 13'h0000)
    begin
      tmr_q <= tmr_q - 13'h0001;
      if (tmr_q == 13'h0001)
        tmr_end_q <= 1'b1;
    end
  end
  wire if1_full = ~w1_rdy;
  wire if2_full = ~w2_rdy;
  assign irq_flag_out = (r12_q[`TFM_IRQ_IF1_BIT] & if1_full) | (r12_q[`TFM_IRQ_IF2_BIT] & if2_full)
    | (r12_q[`TFM_IRQ_PLL_BIT] & ~pll_ok) | (r12_q[`TFM_IRQ_EMPTY_BIT] & (st_q == S_IDLE))
    | (r12_q[`TFM_IRQ_TIMER_BIT] & tmr_end_q);
  assign err_flag_out = (r11_q[`TFM_ERR_IF1_BIT] & if1_full) | (r11_q[`TFM_ERR_IF2_BIT] & if2_full)
    | (r11_q[`TFM_ERR_PLL_BIT] & ~pll_ok);
  // Read data mux with status word at address 10
  wire [DW-1:0] stat = {16'h0000, 4'h0, fine_on, tmr_end_q, err_flag_out, irq_flag_out,
    fifo_level_flag2_out, fifo_level_flag1_out, fifo_empty_flag2_out, fifo_empty_flag1_out};
  reg [DW-1:0] rsel;
  always @*
  begin
    case (bus_addr_in)
      `TFM_REG_FIFO1: rsel = f1_d;
      `TFM_REG_FIFO2: rsel = f2_d;
      `TFM_REG_STAT: rsel = stat;
      `TFM_REG_OPT: rsel = r5_q;
      `TFM_REG_FILL: rsel = r6_q;
      default: rsel = 28'h0000000;
    endcase
  end
  // Read data captured once per strobe so a FIFO pop cannot change it while the host still reads
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
      bus_data_out <= 28'h0000000;
    else if (rd_fall)
      bus_data_out <= (bus16_q & half_q) ? {16'h0000, rsel[27:16]} : (bus16_q ? {12'h000, rsel[15:0]} : rsel);
  end
  assign bus_data_oe_n_out = ~(rd_act | oe_low);
endmodule
`default_nettype wire

// *** tb/tfm_host.sv ***
// Purpose: Host processor model on the parallel register bus
// Assumes: Strobes held 8 clocks, then 4 idle clocks
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module tfm_host (
  input wire logic clk_in,
  input wire logic [27:0] rdata_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [3:0] addr_out,
  output logic [27:0] data_out
);
  // Idle bus at time zero
  initial
  begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    addr_out = 4'h0;
    data_out = 28'hFFFFFFF;
  end
  // Write cycle, strobe held past the synchroniser
  task automatic wr(input logic [3:0] a, input logic [27:0] d);
  begin
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    wr_n_out <= 1'b0;
    addr_out <= a;
    data_out <= d;
    repeat (8) @(posedge clk_in);
    cs_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    data_out <= ~d;
    repeat (4) @(posedge clk_in);
  end
  endtask
  // Read cycle, data taken at the edge before release
  task automatic rd(input logic [3:0] a, output logic [27:0] d);
  begin
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    rd_n_out <= 1'b0;
    addr_out <= a;
    repeat (8) @(posedge clk_in);
    d = rdata_in;
    cs_n_out <= 1'b1;
    rd_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
  end
  endtask
endmodule
`default_nettype wire

// *** tb/tfm_ctrl_monitor.sv ***
// Purpose: Port-level checks on the measure control block
// Assumes: Single clock, synchronous active-high reset
// Notes: Bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
module tfm_ctrl_monitor #(
  parameter DW = 28
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic power_up_reset_n_in,
  input wire logic bus_cs_n_in,
  input wire logic bus_rd_n_in,
  input wire logic bus_wr_n_in,
  input wire logic post_process_trigger_pin_in,
  input wire logic output_drive_pin_n_in,
  input wire logic [DW-1:0] bus_data_out,
  input wire logic bus_data_oe_n_out,
  input wire logic fifo_empty_flag1_out,
  input wire logic fifo_empty_flag2_out,
  input wire logic fifo_level_flag1_out,
  input wire logic fifo_level_flag2_out,
  input wire logic diff_input_power_on_out,
  input wire logic bus16_mode_out
);
  logic [3:0] act_age_q;
  logic [3:0] rd_age_q;
  default clocking mon_cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // ************************************
  // Helper ages
  // ************************************
  // Cycles since a write or a reset
  always_ff @(posedge sys_clk_in)
    if (srst_in || !power_up_reset_n_in || (!bus_wr_n_in && !bus_cs_n_in))
      act_age_q <= 4'h0;
    else if (act_age_q != 4'hF)
      act_age_q <= act_age_q + 4'h1;
  // Cycles since a read, a reset or a reset pin
  always_ff @(posedge sys_clk_in)
    if (srst_in || !power_up_reset_n_in || !bus_rd_n_in || !output_drive_pin_n_in || post_process_trigger_pin_in)
      rd_age_q <= 4'h0;
    else if (rd_age_q != 4'hF)
      rd_age_q <= rd_age_q + 4'h1;
  // ************************************
  // Assertions
  // ************************************
  chk_reset_flags: assert property (disable iff (1'b0)
    srst_in |=> fifo_empty_flag1_out && fifo_empty_flag2_out && !fifo_level_flag1_out && !fifo_level_flag2_out)
    else $error("flags not cleared by reset");
  chk_pup_clear: assert property (
    !power_up_reset_n_in [*5] |-> fifo_empty_flag1_out && !diff_input_power_on_out && !bus16_mode_out)
    else $error("power-up reset did not clear");
  chk_lvl1_nonempty: assert property (fifo_level_flag1_out |-> !fifo_empty_flag1_out)
    else $error("level flag 1 with empty fifo");
  chk_lvl2_nonempty: assert property (fifo_level_flag2_out |-> !fifo_empty_flag2_out)
    else $error("level flag 2 with empty fifo");
  chk_pwr_cause: assert property ($changed(diff_input_power_on_out) |-> act_age_q < 4'h8)
    else $error("power bit changed without write");
  chk_wide_cause: assert property ($changed(bus16_mode_out) |-> act_age_q < 4'h8)
    else $error("bus width changed without write");
  chk_data_cause: assert property ($changed(bus_data_out) |-> rd_age_q < 4'h8)
    else $error("read data changed without read");
  chk_oe_pin: assert property (!output_drive_pin_n_in [*3] |-> !bus_data_oe_n_out)
    else $error("drive pin low but bus not driven");
  chk_oe_idle: assert property ((bus_rd_n_in && output_drive_pin_n_in) [*6] |-> bus_data_oe_n_out)
    else $error("bus driven while idle");
  cov_level: cover property ($rose(fifo_level_flag1_out));
  cov_wide: cover property ($rose(bus16_mode_out));
  cov_pup: cover property (!power_up_reset_n_in [*5]);
endmodule
bind tfm_ctrl tfm_ctrl_monitor #(.DW(DW)) mon_u (.sys_clk_in, .srst_in, .power_up_reset_n_in, .bus_cs_n_in,
  .bus_rd_n_in, .bus_wr_n_in, .post_process_trigger_pin_in, .output_drive_pin_n_in, .bus_data_out,
  .bus_data_oe_n_out, .fifo_empty_flag1_out, .fifo_empty_flag2_out, .fifo_level_flag1_out,
  .fifo_level_flag2_out, .diff_input_power_on_out, .bus16_mode_out);
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the measure control block
// Assumes: 50 ns clock, host model drives the bus
// Notes: Expected values worked out from the settings written
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic pur_n = 1'b1;
  logic start = 1'b0;
  logic stop1 = 1'b0;
  logic stop2 = 1'b0;
  logic [3:0] blk = 4'h0;
  logic [2:0] tst = 3'h0;
  logic trig = 1'b0;
  logic drv_n = 1'b1;
  logic pll = 1'b1;
  logic cs_n, rd_n, wr_n, oe_n, ef1, ef2, lf1, lf2, irq, err, pwr, b16;
  logic [3:0] addr;
  logic [27:0] wdata, rdata, d;
  int errors = 0;
  int comparisons = 0;
  int n;
  // Clock
  always #25 sys_clk_in = ~sys_clk_in;
  tfm_host host_u (.clk_in(sys_clk_in), .rdata_in(rdata), .cs_n_out(cs_n), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .addr_out(addr), .data_out(wdata));
  tfm_ctrl dut_u (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .power_up_reset_n_in(pur_n),
    .bus_cs_n_in(cs_n), .bus_rd_n_in(rd_n), .bus_wr_n_in(wr_n), .bus_addr_in(addr),
    .bus_data_in(wdata), .bus_data_out(rdata), .bus_data_oe_n_out(oe_n), .start_in(start),
    .stop1_in(stop1), .stop2_in(stop2), .test_start_in(tst[2]), .test_stop1_in(tst[1]),
    .test_stop2_in(tst[0]), .stop_input_block_pin_in(blk), .post_process_trigger_pin_in(trig),
    .output_drive_pin_n_in(drv_n), .pll_locked_in(pll), .fifo_empty_flag1_out(ef1),
    .fifo_empty_flag2_out(ef2), .fifo_level_flag1_out(lf1), .fifo_level_flag2_out(lf2),
    .irq_flag_out(irq), .err_flag_out(err), .diff_input_power_on_out(pwr), .bus16_mode_out(b16));
  // Compare and count
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
  begin
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // Verdict and end of run
  task automatic conclude;
  begin
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    errors++;
    conclude();
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    chk({ef1, ef2, lf1, lf2}, 28'hC);
    host_u.wr(4'hB, 28'h4000000);
    host_u.wr(4'hC, 28'h0800000);
    pll <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    chk({irq, err}, 28'h3);
    pll <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk({irq, err}, 28'h0);
    host_u.wr(4'h0, 28'h0000007);
    host_u.wr(4'h3, 28'h000001F);
    host_u.wr(4'h4, 28'h0002200);
    host_u.wr(4'h5, 28'h0000010);
    host_u.wr(4'h6, 28'h8000001);
    chk(pwr, 28'h1);
    // One start, stop1 five clocks later, stop2 blocked by pin
    blk <= 4'h4;
    start <= 1'b1;
    stop2 <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    stop1 <= 1'b1;
    start <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    stop1 <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    stop1 <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    stop1 <= 1'b0;
    stop2 <= 1'b0;
    repeat (30) @(posedge sys_clk_in);
    chk(ef1, 28'h1);
    trig <= 1'b1;
    n = 0;
    @(posedge sys_clk_in);
    while (ef1 !== 1'b0 && n < 60)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    trig <= 1'b0;
    chk(n >= 18, 28'h1);
    chk({lf1, lf2, ef2}, 28'h5);
    host_u.rd(4'h8, d);
    chk(d, 28'h00000B0);
    repeat (4) @(posedge sys_clk_in);
    chk(ef1, 28'h1);
    host_u.rd(4'h1, d);
    chk(d, 28'h0);
    // Timer on start, start taken from the test inputs only
    host_u.wr(4'h7, 28'h0000004);
    host_u.wr(4'hC, 28'h2000000);
    host_u.wr(4'h3, 28'h800001F);
    host_u.wr(4'h4, 28'h0402300);
    start <= 1'b1;
    repeat (10) @(posedge sys_clk_in);
    chk(irq, 28'h0);
    tst <= 3'h4;
    repeat (10) @(posedge sys_clk_in);
    chk(irq, 28'h1);
    start <= 1'b0;
    tst <= 3'h0;
    drv_n <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk(oe_n, 28'h0);
    drv_n <= 1'b1;
    host_u.wr(4'hE, 28'h0000010);
    chk(b16, 28'h1);
    pur_n <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    pur_n <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk({pwr, b16, ef1}, 28'h1);
    conclude();
  end
endmodule
`default_nettype wire
